// >>> hw/anwmp_host.sv
// Purpose: host controller driving an asynchronous 256K x 16 non-volatile memory
// Assumes: power_good reports the supply above its minimum operating level
// Notes: one access at a time, every pin output straight from a flip-flop
`timescale 1ns/1ps

module anwmp_host
  import anwmp_pkg::*;
#(
  parameter int STARTUP_CYCLES = STARTUP_CYC_DEF // shorten for simulation
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic power_good,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  input wire logic [1:0] req_lanes,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_rdata,
  output logic mem_ready,
  output logic [ADDR_W-1:0] mem_addr,
  output logic mem_cs_n,
  output logic mem_we_n,
  output logic mem_oe_n,
  output logic low_lane_n,
  output logic high_lane_n,
  input wire logic [DATA_W-1:0] dq_in,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe
);

  // ******************************************************
  // elaboration checks
  // ******************************************************
  if (STARTUP_CYCLES < 1 || STARTUP_CYCLES >= (1 << STARTUP_W)) begin : g_chk_startup
    $error("STARTUP_CYCLES out of range for the startup counter");
  end
  if (READ_CYC >= (1 << TMR_W) || CYCLE_CYC >= (1 << TMR_W)) begin : g_chk_tmr
    $error("phase counts do not fit the phase timer");
  end

  localparam logic [STARTUP_W-1:0] STARTUP_LAST = STARTUP_W'(STARTUP_CYCLES - 1);
  localparam logic [TMR_W-1:0] READ_LOAD = TMR_W'(READ_CYC - 1);
  localparam logic [TMR_W-1:0] WLOW_LOAD = TMR_W'(WLOW_CYC - 1);
  localparam logic [TMR_W-1:0] WREC_LOAD = TMR_W'(WREC_CYC - 1);
  localparam logic [TMR_W-1:0] GAP_LOAD = TMR_W'(GAP_CYC - 1);
  localparam logic [TMR_W-1:0] CYCLE_MIN = TMR_W'(CYCLE_CYC);
  localparam logic [TMR_W-1:0] TMR_ZERO = '0;
  localparam logic [TMR_W-1:0] TMR_ONE = TMR_W'(1);

  // ******************************************************
  // declarations
  // ******************************************************
  anwmp_state_t state; // current phase
  anwmp_state_t next_state; // phase for the next cycle
  logic pg_meta; // first stage, read only by pg_sync
  logic pg_sync; // supply good, safe to use
  logic [DATA_W-1:0] dq_meta; // first stage, read only by dq_sync
  logic [DATA_W-1:0] dq_sync; // read data, safe to use
  logic [STARTUP_W-1:0] startup_cnt; // cycles of good supply seen
  logic [TMR_W-1:0] tmr; // cycles left in the current phase
  logic [TMR_W-1:0] cs_age; // cycles since select last fell, saturating
  logic take; // request accepted this cycle
  logic cs_fall; // select falls at the coming edge
  logic [1:0] lanes; // latched lane enables, high means enabled

  assign take = (state == ANWMP_IDLE) && req_valid && req_ready && pg_sync;
  assign cs_fall = (next_state == ANWMP_READ || next_state == ANWMP_WSET) && state == ANWMP_IDLE;

  // ******************************************************
  // input synchronisers
  // ******************************************************

  // supply level comes from outside the clock domain
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pg_meta <= 1'b0;
      pg_sync <= 1'b0;
    end else begin
      pg_meta <= power_good;
      pg_sync <= pg_meta;
    end
  end

  // data bus pins; two stages cost two cycles of read latency
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      dq_meta <= '0;
      dq_sync <= '0;
    end else begin
      dq_meta <= dq_in;
      dq_sync <= dq_meta;
    end
  end

  // ******************************************************
  // startup wait
  // ******************************************************

  // counts only while supply is good; any dip restarts from zero
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      startup_cnt <= '0;
    end else if (!pg_sync) begin
      startup_cnt <= '0;
    end else if (state == ANWMP_START && startup_cnt != STARTUP_LAST) begin
      startup_cnt <= startup_cnt + 1'b1;
    end
  end

  // ******************************************************
  // phase sequencing
  // ******************************************************

  // next phase; loss of supply overrides everything
  always_comb begin
    next_state = state;
    unique case (state)
      ANWMP_OFF: begin
        next_state = ANWMP_START;
      end
      ANWMP_START: begin
        // leave only after the full wait has elapsed
        if (startup_cnt == STARTUP_LAST) begin
          next_state = ANWMP_IDLE;
        end
      end
      ANWMP_IDLE: begin
        if (req_valid && req_ready) begin
          next_state = req_write ? ANWMP_WSET : ANWMP_READ;
        end
      end
      ANWMP_READ: begin
        if (tmr == TMR_ZERO) begin
          next_state = ANWMP_GAP;
        end
      end
      ANWMP_WSET: begin
        next_state = ANWMP_WLOW;
      end
      ANWMP_WLOW: begin
        if (tmr == TMR_ZERO) begin
          next_state = ANWMP_WREC;
        end
      end
      ANWMP_WREC: begin
        if (tmr == TMR_ZERO) begin
          next_state = ANWMP_GAP;
        end
      end
      ANWMP_GAP: begin
        // both the high time and the fall-to-fall spacing must be met
        if (tmr == TMR_ZERO && cs_age >= CYCLE_MIN) begin
          next_state = ANWMP_IDLE;
        end
      end
    endcase
    if (!pg_sync) begin
      next_state = ANWMP_OFF;
    end
  end

  // phase register
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ANWMP_OFF;
    end else begin
      state <= next_state;
    end
  end

  // phase timer, loaded on entry to each timed phase
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tmr <= '0;
    end else if (next_state != state) begin
      unique case (next_state)
        ANWMP_READ: tmr <= READ_LOAD;
        ANWMP_WLOW: tmr <= WLOW_LOAD;
        ANWMP_WREC: tmr <= WREC_LOAD;
        ANWMP_GAP: tmr <= GAP_LOAD;
        default: tmr <= TMR_ZERO;
      endcase
    end else if (tmr != TMR_ZERO) begin
      tmr <= tmr - TMR_ONE;
    end
  end

  // age of the last select fall; saturates so it never wraps
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cs_age <= CYCLE_MIN;
    end else if (cs_fall) begin
      cs_age <= TMR_ZERO;
    end else if (cs_age < CYCLE_MIN) begin
      cs_age <= cs_age + TMR_ONE;
    end
  end

  // ******************************************************
  // user side handshake
  // ******************************************************

  // ready mirrors the idle phase one edge ahead
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      req_ready <= 1'b0;
      mem_ready <= 1'b0;
    end else begin
      req_ready <= (next_state == ANWMP_IDLE) && !take;
      mem_ready <= (next_state != ANWMP_OFF) && (next_state != ANWMP_START);
    end
  end

  // read answer: synchronised data, disabled lanes read as zero
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end else begin
      rsp_valid <= 1'b0;
      if (state == ANWMP_READ && tmr == TMR_ZERO && pg_sync) begin
        rsp_valid <= 1'b1;
        rsp_rdata[LANE_W-1:0] <= lanes[0] ? dq_sync[LANE_W-1:0] : '0;
        rsp_rdata[DATA_W-1:LANE_W] <= lanes[1] ? dq_sync[DATA_W-1:LANE_W] : '0;
      end
    end
  end

  // ******************************************************
  // memory pins
  // ******************************************************

  // address, write data and lanes latch with the request and stay put
  // through recovery, so no address moves while a strobe is low
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mem_addr <= '0;
      dq_out <= '0;
      lanes <= 2'h0;
    end else if (take) begin
      mem_addr <= req_addr;
      dq_out <= req_wdata;
      lanes <= req_lanes;
    end
  end

  // select low in the access phases; parked high at reset and power loss
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mem_cs_n <= 1'b1;
    end else begin
      mem_cs_n <= !(next_state == ANWMP_READ || next_state == ANWMP_WSET ||
                    next_state == ANWMP_WLOW || next_state == ANWMP_WREC);
    end
  end

  // strobe low only inside a selected write; never in a read
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mem_we_n <= 1'b1;
    end else begin
      mem_we_n <= !(next_state == ANWMP_WLOW);
    end
  end

  // output enable only for reads, so the device never fights our drive
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mem_oe_n <= 1'b1;
    end else begin
      mem_oe_n <= !(next_state == ANWMP_READ);
    end
  end

  // lane enables follow select so a deselected lane stays idle
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      low_lane_n <= 1'b1;
      high_lane_n <= 1'b1;
    end else if (take) begin
      low_lane_n <= !req_lanes[0];
      high_lane_n <= !req_lanes[1];
    end else if (next_state == ANWMP_GAP || next_state == ANWMP_OFF) begin
      low_lane_n <= 1'b1;
      high_lane_n <= 1'b1;
    end
  end

  // data drive spans setup, strobe and recovery; the gap phase after a
  // read gives the device time to release the bus before we drive it
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      dq_oe <= 1'b0;
    end else begin
      dq_oe <= (next_state == ANWMP_WSET || next_state == ANWMP_WLOW ||
                next_state == ANWMP_WREC);
    end
  end

endmodule

// >>> hw/anwmp_pkg.sv
// Purpose: shared constants for the non-volatile word memory host port
// Assumes: core_clk at 40 MHz, times held in their own units
// Notes: cycle counts derive from the times and the clock period
package anwmp_pkg;

  // ******************************************************
  // clock and memory geometry
  // ******************************************************
  localparam int CLK_NS = 25; // core_clk period in ns
  localparam int ADDR_W = 18; // word address width
  localparam int DATA_W = 16; // word width
  localparam int LANE_W = 8; // byte lane width

  // ******************************************************
  // pin timing, figures in ns (ms for startup)
  // ******************************************************
  localparam int STARTUP_MS = 2; // power-up wait before any access
  localparam int T_CYCLE_NS = 35; // cycle time, chip select fall to fall
  localparam int T_ACCESS_NS = 35; // read access from address or select
  localparam int T_WPULSE_NS = 15; // write strobe low width
  localparam int T_AVWH_NS = 20; // address valid to write end, worst case
  localparam int T_DVWH_NS = 10; // data valid to write end
  localparam int T_WREC_NS = 12; // address hold after strobe rises
  localparam int T_HIGH_NS = 2; // steady-high time of a raised control
  localparam int T_EHQZ_NS = 15; // device release after select rises

  // least time rounded up to whole cycles, never below one
  function automatic int ns_to_cyc(input int t_ns);
    int c;
    c = (t_ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int max3(input int a, input int b, input int c);
    int m;
    m = (a > b) ? a : b;
    return (m > c) ? m : c;
  endfunction

  // ******************************************************
  // derived cycle counts
  // ******************************************************
  localparam int SYNC_STAGES = 2; // input synchroniser depth
  localparam int STARTUP_CYC_DEF = STARTUP_MS * 1000000 / CLK_NS; // 80000
  localparam int CYCLE_CYC = ns_to_cyc(T_CYCLE_NS);
  localparam int READ_CYC = ns_to_cyc(T_ACCESS_NS) + SYNC_STAGES;
  localparam int WLOW_CYC = max3(ns_to_cyc(T_WPULSE_NS), ns_to_cyc(T_AVWH_NS), ns_to_cyc(T_DVWH_NS));
  localparam int WREC_CYC = ns_to_cyc(T_WREC_NS);
  localparam int GAP_CYC = max3(ns_to_cyc(T_HIGH_NS), ns_to_cyc(T_EHQZ_NS), 1);
  localparam int TMR_W = 4; // phase timer width
  localparam int STARTUP_W = 20; // startup counter width

  // ******************************************************
  // controller states, one-hot
  // ******************************************************
  typedef enum logic [7:0] {
    ANWMP_OFF = 8'h01, // supply low, pins parked high
    ANWMP_START = 8'h02, // startup wait
    ANWMP_IDLE = 8'h04, // ready for a request
    ANWMP_READ = 8'h08, // select and output enable low
    ANWMP_WSET = 8'h10, // select low, data driven, strobe high
    ANWMP_WLOW = 8'h20, // write strobe low
    ANWMP_WREC = 8'h40, // strobe high, address and data held
    ANWMP_GAP = 8'h80 // select high, spacing and turnaround
  } anwmp_state_t;

endpackage

// >>> bench/anwmp_assertions.sv
// Purpose: pin and handshake checks for the memory host port
// Assumes: bound to anwmp_host, sees its ports only
// Notes: startup count is handed on from the bound instance
`timescale 1ns/1ps
module anwmp_assertions
  import anwmp_pkg::*;
#(
  parameter int STARTUP_CYCLES = STARTUP_CYC_DEF
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic power_good,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [1:0] req_lanes,
  input wire logic rsp_valid,
  input wire logic mem_ready,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic mem_cs_n,
  input wire logic mem_we_n,
  input wire logic mem_oe_n,
  input wire logic low_lane_n,
  input wire logic high_lane_n,
  input wire logic [DATA_W-1:0] dq_out,
  input wire logic dq_oe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  int pg_run; // supply-good edges in a row, saturating
  int cs_cyc; // edges since select last fell, saturating
  // ****
  // helper: supply-good run length
  // ****
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pg_run <= 0;
    end else begin
      pg_run <= !power_good ? 0 : (pg_run < STARTUP_CYCLES) ? pg_run + 1 : pg_run;
    end
  end
  // helper: spacing of select falls, restarts at each fall
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cs_cyc <= CYCLE_CYC;
    end else begin
      cs_cyc <= $fell(mem_cs_n) ? 1 : (cs_cyc < CYCLE_CYC) ? cs_cyc + 1 : cs_cyc;
    end
  end
  // ****
  // properties
  // ****
  AST_PARK: assert property (!mem_ready && !$fell(mem_ready) |-> mem_cs_n && mem_we_n && !dq_oe)
    else $error("controls not parked");
  AST_STARTUP: assert property ($rose(mem_ready) |-> pg_run == STARTUP_CYCLES)
    else $error("ready before startup wait");
  AST_WE_IN_CS: assert property (!mem_we_n |-> !mem_cs_n && !$fell(mem_cs_n) && mem_oe_n)
    else $error("strobe low outside select");
  AST_READ_PINS: assert property (!mem_oe_n |-> mem_we_n && !mem_cs_n && !dq_oe)
    else $error("bad read pins");
  AST_TAKE: assert property (req_valid && req_ready ##1 mem_ready |-> $fell(mem_cs_n)
    && mem_addr == $past(req_addr) && {high_lane_n, low_lane_n} == ~$past(req_lanes)
    && dq_oe == $past(req_write))
    else $error("bad access start");
  AST_CYCLE: assert property ($fell(mem_cs_n) |-> cs_cyc >= CYCLE_CYC)
    else $error("select falls too close together");
  AST_WPULSE: assert property ($fell(mem_we_n) |-> dq_oe && $stable(mem_addr) && $stable(dq_out) ##1 mem_we_n)
    else $error("bad write pulse");
  AST_WREC: assert property ($rose(mem_we_n) && !mem_cs_n |-> dq_oe && $stable(mem_addr) && $stable(dq_out))
    else $error("no write recovery");
  AST_HIGH: assert property ($rose(mem_cs_n) |=> mem_cs_n)
    else $error("select high too short");
  AST_RSP: assert property (req_valid && req_ready && !req_write |=> !rsp_valid [*4] ##1 (rsp_valid || !mem_ready))
    else $error("read answer late or early");
endmodule

bind anwmp_host anwmp_assertions #(.STARTUP_CYCLES(STARTUP_CYCLES)) u_anwmp_assertions (.core_clk, .arst_n,
  .power_good, .req_valid, .req_ready, .req_write, .req_addr, .req_lanes, .rsp_valid, .mem_ready, .mem_addr,
  .mem_cs_n, .mem_we_n, .mem_oe_n, .low_lane_n, .high_lane_n, .dq_out, .dq_oe);

// >>> bench/anwmp_mem_model.sv
// Purpose: behavioural model of the word memory on the host pins
// Assumes: no clock, pins change on host clock edges
// Notes: undriven lanes show a toggling pattern, never the last value
`timescale 1ns/1ps
module anwmp_mem_model
  import anwmp_pkg::*;
(
  input wire logic power_good,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic mem_cs_n,
  input wire logic mem_we_n,
  input wire logic mem_oe_n,
  input wire logic low_lane_n,
  input wire logic high_lane_n,
  input wire logic [DATA_W-1:0] dq_out,
  input wire logic dq_oe,
  output logic [DATA_W-1:0] dq_in
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1]; // full word store
  logic [DATA_W-1:0] q = '0; // read data after access delay
  logic [1:0] en = 2'h0; // lane drive enables
  logic flt = 1'b0; // float pattern phase
  wire wr = !mem_cs_n && !mem_we_n; // write overlap
  always #10 flt = ~flt;
  // write lands as the overlap ends, locked out on low supply
  always @(negedge wr) begin
    if (power_good === 1'b1) begin
      if (low_lane_n === 1'b0) mem[mem_addr][7:0] = dq_out[7:0];
      if (high_lane_n === 1'b0) mem[mem_addr][15:8] = dq_out[15:8];
    end
  end
  // float soon after any change, old data kept 8 ns; drive within access time
  always @(mem_addr or mem_cs_n or mem_we_n or mem_oe_n or low_lane_n or high_lane_n) begin
    en <= #8 2'h0;
    if (mem_cs_n === 1'b0 && mem_oe_n === 1'b0 && mem_we_n === 1'b1) begin
      q <= #20 mem[mem_addr];
      en <= #20 {~high_lane_n, ~low_lane_n};
    end
  end
  assign dq_in = dq_oe ? dq_out : {en[1] ? q[15:8] : {8{flt}}, en[0] ? q[7:0] : {8{~flt}}};
endmodule

// >>> bench/anwmp_host_bench.sv
// Purpose: self-checking bench for the memory host port
// Assumes: startup shortened to 20 cycles
// Notes: device model on the pins, inputs moved 1 ns after the edge
`timescale 1ns/1ps
module anwmp_host_bench
  import anwmp_pkg::*;
;
  localparam int SU = 20; // shortened startup count
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic power_good = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [ADDR_W-1:0] req_addr = '0;
  logic [DATA_W-1:0] req_wdata = '0;
  logic [1:0] req_lanes = 2'h0;
  logic req_ready, rsp_valid, mem_ready, mem_cs_n, mem_we_n, mem_oe_n, low_lane_n, high_lane_n, dq_oe;
  logic [DATA_W-1:0] rsp_rdata, dq_in, dq_out;
  logic [ADDR_W-1:0] mem_addr;
  int miscompares = 0;
  int tests_run = 0;
  always #12.5 core_clk = ~core_clk;
  anwmp_host #(.STARTUP_CYCLES(SU)) u_anwmp_host (.core_clk, .arst_n, .power_good, .req_valid, .req_ready,
    .req_write, .req_addr, .req_wdata, .req_lanes, .rsp_valid, .rsp_rdata, .mem_ready, .mem_addr, .mem_cs_n,
    .mem_we_n, .mem_oe_n, .low_lane_n, .high_lane_n, .dq_in, .dq_out, .dq_oe);
  anwmp_mem_model u_anwmp_mem_model (.power_good, .mem_addr, .mem_cs_n, .mem_we_n, .mem_oe_n, .low_lane_n,
    .high_lane_n, .dq_out, .dq_oe, .dq_in);
  // ****
  // shared tasks
  // ****
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // hold the request until an edge sees ready high
  task automatic req(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic [1:0] l);
    int n;
    n = 0;
    tick(1);
    req_valid = 1'b1;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    req_lanes = l;
    @(posedge core_clk);
    while (req_ready !== 1'b1 && n < 40) begin
      n++;
      @(posedge core_clk);
    end
    #1;
    req_valid = 1'b0;
    check(n < 40, 1'b1);
  endtask
  // read, then judge the data and the answer delay
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [1:0] l, input logic [DATA_W-1:0] e);
    int n;
    n = 0;
    req(1'b0, a, 16'h0000, l);
    while (rsp_valid !== 1'b1 && n < 10) begin
      tick(1);
      n++;
    end
    check({n[7:0], rsp_rdata}, {8'(READ_CYC), e});
  endtask
  task automatic power_up();
    int n;
    n = 0;
    power_good = 1'b1;
    while (mem_ready !== 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    check(n >= SU && n < SU + 8, 1'b1);
  endtask
  // ****
  // scenarios
  // ****
  // each non-empty lane mask over a full word, one per address: low end, high end, middle
  task automatic t_lanes();
    logic [ADDR_W-1:0] a;
    logic [DATA_W-1:0] m;
    for (int l = 1; l < 4; l++) begin
      a = (l == 1) ? 18'h00000 : (l == 2) ? 18'h3FFFF : 18'h15A5A;
      m = {{8{l[1]}}, {8{l[0]}}};
      req(1'b1, a, 16'hA5C3, 2'h3);
      req(1'b1, a, 16'h5A3C, l[1:0]);
      rd(a, 2'h3, (16'h5A3C & m) | (16'hA5C3 & ~m));
      rd(a, l[1:0], 16'h5A3C & m);
    end
  endtask
  // supply drop aborts a read, parks pins, keeps stored data
  task automatic t_brownout();
    logic seen;
    seen = 1'b0;
    req(1'b1, 18'h2AAAA, 16'hBEEF, 2'h3);
    req(1'b0, 18'h2AAAA, 16'h0000, 2'h3);
    power_good = 1'b0;
    repeat (8) begin
      tick(1);
      seen = seen | rsp_valid;
    end
    check(seen, 1'b0);
    check({mem_ready, mem_cs_n, mem_we_n, dq_oe}, 4'h6);
    power_up();
    rd(18'h2AAAA, 2'h3, 16'hBEEF);
  endtask
  initial begin
    tick(6);
    check({req_ready, mem_ready, mem_cs_n, mem_we_n, mem_oe_n, low_lane_n, high_lane_n, dq_oe}, 8'h3E);
    arst_n = 1'b1;
    tick(10);
    check({req_ready, mem_ready, mem_cs_n, mem_we_n, mem_oe_n, low_lane_n, high_lane_n, dq_oe}, 8'h3E);
    power_up();
    t_lanes();
    t_brownout();
    results();
  end
  // watchdog well past the expected run
  initial begin
    #(CLK_NS * 4000);
    miscompares++;
    results();
  end
endmodule
